// ### include/wwdt_pkg.sv
// Package for the windowed watchdog timer: register map, field layout,
// reset values and timing counts.
// Assumes a single 250 MHz clock and an AHB-Lite register bus.
package wwdt_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] WWDT_CTRL_OFS = 8'h24;
  localparam logic [7:0] WWDT_STAT_OFS = 8'h28;
  localparam logic [7:0] WWDT_ADDR_MASK = 8'hFF;
  // Control register fields
  localparam int WWDT_ACT_POS = 7;
  localparam int WWDT_TOP_POS = 6;
  localparam logic [7:0] WWDT_CTRL_RST = 8'h7F;
  // Count value whose next step clears the top count bit
  localparam logic [6:0] WWDT_ROLL_CNT = 7'h40;
  // Prescaler length in machine cycles per count step
  localparam int WWDT_PRESC_CYC = 12288;
  // Wake-up restart delay in CPU clocks
  localparam int WWDT_WAKE_CYC = 4096;
  // Chip reset pulse, typical width in ns, and its clock count
  localparam int WWDT_RST_NS = 500;
  localparam int WWDT_CLK_NS = 4;
  localparam int WWDT_RST_CYC = WWDT_RST_NS / WWDT_CLK_NS;
  // Status register bit positions
  localparam int WWDT_ST_HALT = 0;
  localparam int WWDT_ST_WAKE = 1;
  localparam int WWDT_ST_FIRED = 2;
  localparam int WWDT_ST_ACT = 3;
  // AHB transfer codes
  localparam logic [1:0] WWDT_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] WWDT_HSIZE_WORD = 3'h2;
endpackage

// ### include/wwdt_cnt_if.sv
// Interface between the watchdog core and its cycle counter.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface wwdt_cnt_if;
  logic restart; // Restart the count from zero
  logic run; // Count enable
  logic done; // One-cycle pulse at the end of the period
  modport ctrl (output restart, output run, input done);
  modport cnt (input restart, input run, output done);
endinterface
`default_nettype wire

// ### core/wwdt_cycle_cnt.sv
// Cycle counter giving one done pulse every PERIOD enabled cycles.
// Assumes restart and run are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module wwdt_cycle_cnt #(
  parameter int PERIOD = 12288
) (
  input wire logic hclk,
  input wire logic hresetn,
  wwdt_cnt_if.cnt port_c
);
  import wwdt_pkg::*;
  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  logic [W-1:0] count; // Cycles elapsed in this period
  wire at_last = (count == LAST);
  // Count, wrap and pulse; restart takes priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      port_c.done <= 1'b0;
    end else if (port_c.restart) begin
      count <= '0;
      port_c.done <= 1'b0;
    end else begin
      port_c.done <= port_c.run && at_last;
      if (port_c.run) begin
        count <= at_last ? '0 : count + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ### core/wwdt_core.sv
// Windowed watchdog timer core with AHB-Lite register access.
// Assumes hclk is the CPU clock; halt and wake strobes come from the CPU.
//
// Notes on behaviour
// R1 - Count steps down every 12288 cycles
// R2 - Active and 40h to 3Fh: reset pulse
// R3 - Software refreshes with C0h to FFh
// R4 - Low six bits give 64 delay steps
// R5 - Reset leaves watchdog disabled
// R6 - Software cannot clear activation once set
// R7 - Activate with top bit clear forces reset
// R8 - Hardware option makes watchdog always active
// R9 - Wait mode changes nothing
// R10 - Halt with reset option: immediate reset
// R11 - Halt freezes count, no reset
// R12 - After wake, resume after 4096 clocks
// R13 - Software refreshes before halt
// R14 - Control resets to 7Fh
// R15 - Write loads count, restarts prescaler
// R16 - One request per expiry until chip reset
`timescale 1ns/1ps
`default_nettype none
module wwdt_core #(
  parameter int PRESC_CYC = wwdt_pkg::WWDT_PRESC_CYC,
  parameter int WAKE_CYC = wwdt_pkg::WWDT_WAKE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hw_watchdog,
  input wire logic reset_on_halt,
  input wire logic halt_exec,
  input wire logic wait_exec,
  input wire logic ext_wake,
  output logic reset_req,
  output logic reset_pin_n
);
  import wwdt_pkg::*;

  // Halt state machine, one-hot
  typedef enum logic [2:0] {
    WWDT_RUN = 3'h1,
    WWDT_HALT = 3'h2,
    WWDT_WAKE = 3'h4
  } wwdt_state_t;

  localparam int RW = $clog2(WWDT_RST_CYC + 1);
  localparam logic [RW-1:0] RST_LEN = RW'(WWDT_RST_CYC);

  wwdt_state_t state; // Low power tracking
  wwdt_state_t next_state;
  logic activation_bit; // Watchdog enabled by software
  logic [6:0] countdown_value; // Decrementing count
  logic fired; // Expiry seen, blocks another request
  logic [RW-1:0] pin_cnt; // Reset pin low time left
  // Registered address phase
  logic dp_wr;
  logic dp_rd;
  logic [7:0] dp_addr;

  wwdt_cnt_if presc_if();
  wwdt_cnt_if wake_if();

  // Address phase decode
  wire addr_ok = hsel && hready && (htrans == WWDT_HTRANS_NONSEQ);

  // Decode a byte offset against the register window
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_ctrl = dp_wr && hit(dp_addr, WWDT_CTRL_OFS);
  wire [7:0] wbyte = hwdata[7:0];
  // Hardware option overrides the software bit
  wire active = activation_bit || hw_watchdog; // R8
  wire running = (state == WWDT_RUN);
  // Wait mode has no influence on counting
  // Wait strobe is read only by an assertion below, never by the logic
  wire count_en = running; // R9 R11
  // Top bit falling from a step of the counter
  wire step = presc_if.done && running;
  wire [6:0] stepped = countdown_value - 7'h01; // R1
  wire roll = step && (countdown_value == WWDT_ROLL_CNT); // R2
  // Write while enabled (written activation bit, activation bit or hardware option) with top bit clear
  wire w_act = wbyte[WWDT_ACT_POS] || activation_bit || hw_watchdog;
  wire sw_force = wr_ctrl && w_act && !wbyte[WWDT_TOP_POS]; // R7
  wire halt_kill = halt_exec && reset_on_halt && active && running; // R10
  // A write in the same cycle as a step wins, so a refresh that lands
  // on the rollover edge is never punished with a reset
  // Limitation: after one expiry only the chip reset re-arms the request
  wire expire = !fired && ((active && roll && !wr_ctrl) || sw_force || halt_kill);

  assign presc_if.restart = wr_ctrl; // R15
  assign presc_if.run = count_en;
  assign wake_if.restart = !(state == WWDT_WAKE);
  assign wake_if.run = (state == WWDT_WAKE);

  // Prescaler between count steps
  wwdt_cycle_cnt #(.PERIOD(PRESC_CYC)) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_c(presc_if.cnt)
  );

  // Wake-up restart delay
  // Restarted on every entry, so a short halt cannot shorten it;
  // the exit costs one extra clock for the registered done pulse
  wwdt_cycle_cnt #(.PERIOD(WAKE_CYC)) u_wake (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_c(wake_if.cnt)
  );

  // Next low-power state
  always_comb begin
    next_state = state;
    case (state)
      WWDT_RUN: begin
        if (halt_exec && !halt_kill) begin
          next_state = WWDT_HALT; // R11
        end
      end
      WWDT_HALT: begin
        if (ext_wake) begin
          next_state = WWDT_WAKE;
        end
      end
      WWDT_WAKE: begin
        if (wake_if.done) begin
          next_state = WWDT_RUN; // R12
        end
      end
      default: begin
        next_state = WWDT_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= WWDT_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Control register: set-only activation, load or decrement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      activation_bit <= 1'b0; // R5 R14
      countdown_value <= WWDT_CTRL_RST[6:0]; // R14
    end else if (wr_ctrl) begin
      activation_bit <= activation_bit | wbyte[WWDT_ACT_POS]; // R6
      countdown_value <= wbyte[6:0]; // R4 R15
    end else if (step) begin
      countdown_value <= stepped; // R1
    end
  end

  // Expiry latch and one-cycle request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fired <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      fired <= fired | expire; // R16
      reset_req <= expire; // R16
    end
  end

  // Reset pin held low for the pulse width
  // Never stretched: the fired latch blocks a second expiry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cnt <= '0;
      reset_pin_n <= 1'b1;
    end else if (expire) begin
      pin_cnt <= RST_LEN;
      reset_pin_n <= 1'b0; // R2
    end else if (pin_cnt > RW'(1)) begin
      pin_cnt <= pin_cnt - RW'(1);
    end else begin
      pin_cnt <= '0;
      reset_pin_n <= 1'b1;
    end
  end

  // Bus data phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= '0;
    end else begin
      dp_wr <= addr_ok && hwrite;
      dp_rd <= addr_ok && !hwrite;
      dp_addr <= haddr[7:0] & WWDT_ADDR_MASK;
    end
  end

  // Read mux; unmapped reads zero
  wire [31:0] ctrl_word = {24'h000000, activation_bit, countdown_value};
  wire [31:0] stat_word = {28'h0000000, active, fired,
                           state == WWDT_WAKE, state == WWDT_HALT};
  wire rd_ctrl = addr_ok && !hwrite && hit(haddr[7:0], WWDT_CTRL_OFS);
  wire rd_stat = addr_ok && !hwrite && hit(haddr[7:0], WWDT_STAT_OFS);

  // Read data registered for the data phase; zero-wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h00000000);
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Assertions
  property p_step;
    @(posedge hclk) disable iff (!hresetn)
    (step && !wr_ctrl) |=> (countdown_value == $past(countdown_value) - 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("count did not step"); // R1

  property p_roll;
    @(posedge hclk) disable iff (!hresetn)
    (active && roll && !wr_ctrl && !fired) |=> (reset_req && !reset_pin_n);
  endproperty
  a_roll: assert property (p_roll) else $error("no reset on rollover"); // R2

  property p_act_sticky;
    @(posedge hclk) disable iff (!hresetn)
    activation_bit |=> activation_bit;
  endproperty
  a_act_sticky: assert property (p_act_sticky) else $error("activation cleared"); // R6

  property p_force;
    @(posedge hclk) disable iff (!hresetn)
    (wr_ctrl && wbyte[WWDT_ACT_POS] && !wbyte[WWDT_TOP_POS] && !fired) |=> reset_req;
  endproperty
  a_force: assert property (p_force) else $error("forced reset missing"); // R7

  property p_halt_kill;
    @(posedge hclk) disable iff (!hresetn)
    (halt_kill && !fired) |=> reset_req;
  endproperty
  a_halt_kill: assert property (p_halt_kill) else $error("halt reset missing"); // R10

  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    (state == WWDT_HALT && !wr_ctrl) |=> $stable(countdown_value);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved in halt"); // R11

  sequence s_wake_start;
    $rose(state == WWDT_WAKE);
  endsequence
  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
    s_wake_start |-> (state == WWDT_WAKE) [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("woke too early"); // R12

  property p_single;
    @(posedge hclk) disable iff (!hresetn)
    reset_req |=> !reset_req;
  endproperty
  a_single: assert property (p_single) else $error("request longer than one"); // R16

  property p_load;
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> (countdown_value == $past(wbyte[6:0]));
  endproperty
  a_load: assert property (p_load) else $error("write did not load"); // R15

  // Wait mode must not hold back a step
  property p_wait;
    @(posedge hclk) disable iff (!hresetn)
    (wait_exec && step && !wr_ctrl) |=> (countdown_value == $past(countdown_value) - 7'h01);
  endproperty
  a_wait: assert property (p_wait) else $error("count held in wait mode"); // R9

  // Pin goes low with a full width loaded
  sequence s_pin_start;
    !reset_pin_n && (pin_cnt == RST_LEN);
  endsequence
  property p_pin;
    @(posedge hclk) disable iff (!hresetn)
    expire |=> s_pin_start;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin pulse not started"); // R2

  property p_pin_hold;
    @(posedge hclk) disable iff (!hresetn)
    (pin_cnt > RW'(1)) |=> !reset_pin_n;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("reset pin released early"); // R2

  property p_halt_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (state == WWDT_HALT && !wr_ctrl) |=> !reset_req;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("reset while halted"); // R11

  property p_idle;
    @(posedge hclk) disable iff (!hresetn)
    (!active && !wr_ctrl) |=> !reset_req;
  endproperty
  a_idle: assert property (p_idle) else $error("reset while disabled"); // R5

  property p_fired;
    @(posedge hclk) disable iff (!hresetn)
    fired |=> (fired && !reset_req);
  endproperty
  a_fired: assert property (p_fired) else $error("second request after expiry"); // R16

  property p_halt_enter;
    @(posedge hclk) disable iff (!hresetn)
    (running && halt_exec && !halt_kill) |=> (state == WWDT_HALT);
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered"); // R11

  property p_wake_enter;
    @(posedge hclk) disable iff (!hresetn)
    (state == WWDT_HALT && ext_wake) |=> (state == WWDT_WAKE);
  endproperty
  a_wake_enter: assert property (p_wake_enter) else $error("wake not taken"); // R12

  property p_halt_run;
    @(posedge hclk) disable iff (!hresetn)
    halt_kill |=> running;
  endproperty
  a_halt_run: assert property (p_halt_run) else $error("halted instead of reset"); // R10
endmodule
`default_nettype wire

// ### test/wwdt_tb.sv
// Self-checking bench for the watchdog core: AHB-Lite tasks and scenarios.
// Assumes the core answers with zero wait states and shortened counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wwdt_pkg::*;
  localparam int PRESC = 16; // Shortened step period
  localparam int WAKE = 8; // Shortened wake delay
  localparam int STEP = PRESC; // Cycles per count step; the first after a load adds one
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, reset_req, reset_pin_n;
  logic hw_watchdog = 1'b0; // Option inputs
  logic reset_on_halt = 1'b0;
  logic halt_exec = 1'b0;
  logic wait_exec = 1'b0;
  logic ext_wake = 1'b0;
  int err_total = 0;
  int num_checks = 0;
  int req_cnt, pin_low; // Monitor counts, cleared by reset
  int n, steps;
  logic [31:0] rd, rd2;
  logic [7:0] vals [4] = '{8'hC0, 8'hC1, 8'hC3, 8'hFF}; // Delay boundaries

  // Clock at 250 MHz
  always #2 hclk = ~hclk;

  wwdt_core #(.PRESC_CYC(PRESC), .WAKE_CYC(WAKE)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hw_watchdog(hw_watchdog), .reset_on_halt(reset_on_halt),
    .halt_exec(halt_exec), .wait_exec(wait_exec), .ext_wake(ext_wake),
    .reset_req(reset_req), .reset_pin_n(reset_pin_n)
  );

  // Counts request pulses and pin-low cycles since the last reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_cnt <= 0;
      pin_low <= 0;
    end else begin
      if (reset_req === 1'b1) req_cnt <= req_cnt + 1;
      if (reset_pin_n === 1'b0) pin_low <= pin_low + 1;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Range check on a cycle count
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= WWDT_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= WWDT_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Chip reset with chosen options, held 8 cycles
  task automatic do_reset(input logic hw, input logic roh);
    @(posedge hclk);
    hresetn <= 1'b0;
    hw_watchdog <= hw;
    reset_on_halt <= roh;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // Cycles until the reset request, bounded
  task automatic wait_req(output int cyc);
    cyc = 0;
    while (reset_req !== 1'b1 && cyc < 3000) begin
      @(posedge hclk);
      cyc++;
    end
  endtask

  task automatic pulse_halt();
    @(posedge hclk);
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
  endtask

  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #100us;
    err_total++;
    final_report();
  end

  initial begin
    do_reset(1'b0, 1'b0);
    bus(1'b0, WWDT_CTRL_OFS, 32'h0);
    chk("ctrl_reset", {24'h0, WWDT_CTRL_RST}, rd);
    bus(1'b0, WWDT_STAT_OFS, 32'h0);
    chk("stat_active", 32'h0, {31'h0, rd[WWDT_ST_ACT]});
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    // Inactive watchdog never resets
    bus(1'b1, WWDT_CTRL_OFS, 32'h41);
    repeat (120) @(posedge hclk);
    chk("inactive_req", 32'h0, req_cnt);
    // Delay boundaries; wait mode held on for C1h to show it changes nothing
    foreach (vals[i]) begin
      do_reset(1'b0, 1'b0);
      wait_exec <= (i == 1);
      bus(1'b1, WWDT_CTRL_OFS, {24'h0, vals[i]});
      bus(1'b0, WWDT_CTRL_OFS, 32'h0);
      chk("ctrl_load", {24'h0, vals[i]}, rd);
      steps = vals[i][5:0] + 1;
      wait_req(n);
      chk_rng("expiry", steps * STEP - 8, steps * STEP + 4, n);
      repeat (200) @(posedge hclk);
      chk("req_count", 32'h1, req_cnt);
      chk("pin_low", WWDT_RST_CYC, pin_low);
    end
    wait_exec <= 1'b0;
    // Activation cannot be cleared by software
    do_reset(1'b0, 1'b0);
    bus(1'b1, WWDT_CTRL_OFS, 32'hFF);
    bus(1'b1, WWDT_CTRL_OFS, 32'h7F);
    bus(1'b0, WWDT_CTRL_OFS, 32'h0);
    chk("act_kept", 32'h1, {31'h0, rd[WWDT_ACT_POS]});
    chk("no_req", 32'h0, req_cnt);
    // Software-forced reset
    bus(1'b1, WWDT_CTRL_OFS, 32'hBF);
    wait_req(n);
    chk_rng("forced", 0, 3, n);
    bus(1'b0, WWDT_STAT_OFS, 32'h0);
    chk("stat_fired", 32'h1, {31'h0, rd[WWDT_ST_FIRED]});
    // Hardware option ignores the activation bit
    do_reset(1'b1, 1'b0);
    bus(1'b1, WWDT_CTRL_OFS, 32'h41);
    wait_req(n);
    chk_rng("hw_expiry", 2 * STEP - 6, 2 * STEP + 4, n);
    // Reset on halt
    do_reset(1'b0, 1'b1);
    bus(1'b1, WWDT_CTRL_OFS, 32'hFF);
    pulse_halt();
    wait_req(n);
    chk_rng("halt_reset", 0, 3, n);
    // Halt freezes the count until a wake, then a delayed restart
    do_reset(1'b0, 1'b0);
    bus(1'b1, WWDT_CTRL_OFS, 32'hC1);
    pulse_halt();
    bus(1'b0, WWDT_CTRL_OFS, 32'h0);
    rd2 = rd;
    repeat (150) @(posedge hclk);
    bus(1'b0, WWDT_CTRL_OFS, 32'h0);
    chk("halt_frozen", rd2, rd);
    chk("halt_no_req", 32'h0, req_cnt);
    bus(1'b0, WWDT_STAT_OFS, 32'h0);
    chk("stat_halt", 32'h1, {31'h0, rd[WWDT_ST_HALT]});
    @(posedge hclk);
    ext_wake <= 1'b1;
    @(posedge hclk);
    ext_wake <= 1'b0;
    wait_req(n);
    chk_rng("wake_resume", WAKE, WAKE + 2 * STEP + 6, n);
    final_report();
  end
endmodule
`default_nettype wire
